// ### src/sswb_device.sv
// stack device end: sleep, wake, reset and balance command handling
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ns
`include "sswb_defines.svh"
module sswb_device (
  input  wire logic   clk,
  input  wire logic   sys_rst,
  sswb_link_if.device link,
  input  wire logic   isTop,
  input  wire logic   isMaster,
  input  wire logic   wdogEn,
  input  wire logic   wdogExpired,
  input  wire logic   balDurDone,
  input  wire logic   autoCycleTick,
  output logic [3:0]  devAddr,
  output logic        asleep,
  output logic        wakeOut,
  output logic        balanceEnableBit,
  output logic [1:0]  balMode,
  output logic [3:0]  patPtr,
  output logic        endOfBalance,
  output logic [11:0] balFet
);
  typedef struct packed {
    sswb_pkg::sswb_state_t st;
    logic [31:0] cnt;
    logic [3:0]  pulses;
    logic        wakeLvl;
    logic        topAckPend;
    logic        rspV;
    sswb_pkg::sswb_rsp_t rsp;
    logic [3:0]  addr;
    logic [3:0]  size;
    logic        balance_enable_bit;
    logic [1:0]  mode;
    logic [3:0]  ptr;
    logic        eob;
    logic [11:0] fet;
    logic [`SSWB_PAT_LOCS*12-1:0] pat;
    logic        w1;
    logic        w2;
    logic        w3;
  } sswb_dev_t;
  sswb_dev_t s_r, s_nxt;
  logic bcast, mine, valid, wakeRise;
  logic [11:0] curPat;
  always_comb begin
    s_nxt = s_r;
    s_nxt.w1 = link.wakeIn;
    s_nxt.w2 = s_r.w1;
    s_nxt.w3 = s_r.w2;
    s_nxt.rspV = 1'b0;
    s_nxt.rsp = sswb_pkg::SSWB_RSP_NONE;
    bcast = link.cmdAddr == `SSWB_ADDR_ALL;
    mine = bcast || link.cmdAddr == s_r.addr;
    // edge taken past the synchroniser so a metastable first stage never reaches logic
    wakeRise = s_r.w2 && !s_r.w3;
    // first port is deaf while the wake burst goes out
    valid = link.cmdValid && s_r.st != sswb_pkg::SSWB_ST_WAKEOUT;
    curPat = s_r.pat[s_r.ptr*12 +: 12];
    case (s_r.st)
      sswb_pkg::SSWB_ST_AWAKE: begin
        if (wdogEn && wdogExpired) begin
          s_nxt.st = sswb_pkg::SSWB_ST_ASLEEP;
        end
      end
      sswb_pkg::SSWB_ST_PEND: begin
        // no fault timeout here; silence is the only symptom
        s_nxt.cnt = s_r.cnt + 32'h1;
        if (valid && link.cmdCode != sswb_pkg::SSWB_CMD_SLEEP) begin
          s_nxt.st = sswb_pkg::SSWB_ST_AWAKE;
        end else if (s_r.cnt >= `SSWB_SLEEP_WAIT_CYC - 1) begin
          s_nxt.st = sswb_pkg::SSWB_ST_ASLEEP;
        end
      end
      sswb_pkg::SSWB_ST_ASLEEP: begin
        if (wakeRise || (valid && isMaster && bcast
            && link.cmdCode == sswb_pkg::SSWB_CMD_WAKE)) begin
          s_nxt.st = sswb_pkg::SSWB_ST_WAKEOUT;
          s_nxt.cnt = 32'h0;
          s_nxt.pulses = 4'h0;
        end
      end
      sswb_pkg::SSWB_ST_WAKEOUT: begin
        s_nxt.cnt = s_r.cnt + 32'h1;
        if (s_r.cnt >= `SSWB_WAKE_HALF_CYC - 1) begin
          s_nxt.cnt = 32'h0;
          s_nxt.wakeLvl = !s_r.wakeLvl;
          if (s_r.wakeLvl) begin
            s_nxt.pulses = s_r.pulses + 4'h1;
            if (s_r.pulses == `SSWB_WAKE_PULSES - 1) begin
              s_nxt.st = sswb_pkg::SSWB_ST_AWAKE;
              s_nxt.topAckPend = isTop;
            end
          end
        end
      end
      default: s_nxt.st = sswb_pkg::SSWB_ST_AWAKE;
    endcase
    if (s_r.topAckPend && s_r.st == sswb_pkg::SSWB_ST_AWAKE) begin
      s_nxt.cnt = s_r.cnt + 32'h1;
      if (s_r.cnt >= `SSWB_TOP_WAIT_CYC - 1) begin
        s_nxt.topAckPend = 1'b0;
        s_nxt.rspV = 1'b1;
        s_nxt.rsp = sswb_pkg::SSWB_RSP_ACK;
        s_nxt.cnt = 32'h0;
      end
    end
    if (valid && mine && s_r.st != sswb_pkg::SSWB_ST_ASLEEP) begin
      case (link.cmdCode)
        sswb_pkg::SSWB_CMD_SLEEP: begin
          if (bcast) begin
            s_nxt.st = sswb_pkg::SSWB_ST_PEND;
            s_nxt.cnt = 32'h0;
            if (isTop) begin
              s_nxt.rspV = 1'b1;
              s_nxt.rsp = sswb_pkg::SSWB_RSP_ACK;
            end
          end else begin
            s_nxt.rspV = 1'b1;
            s_nxt.rsp = sswb_pkg::SSWB_RSP_NAK;
          end
        end
        sswb_pkg::SSWB_CMD_WAKE: begin
          if (!bcast && isMaster) begin
            s_nxt.rspV = 1'b1;
            s_nxt.rsp = sswb_pkg::SSWB_RSP_NAK;
          end
        end
        sswb_pkg::SSWB_CMD_RESET: begin
          if (!bcast) begin
            s_nxt = '0;
            s_nxt.st = sswb_pkg::SSWB_ST_AWAKE;
            s_nxt.w1 = link.wakeIn;
            s_nxt.w2 = s_r.w1;
            s_nxt.w3 = s_r.w2;
          end
        end
        sswb_pkg::SSWB_CMD_BAL_EN: begin
          s_nxt.balance_enable_bit = 1'b1;
          s_nxt.eob = 1'b0;
        end
        sswb_pkg::SSWB_CMD_BAL_INH: s_nxt.balance_enable_bit = 1'b0;
        sswb_pkg::SSWB_CMD_WR_PAT: begin
          if (link.cmdData[15:12] <= `SSWB_PAT_LAST) begin
            s_nxt.pat[link.cmdData[15:12]*12 +: 12] = link.cmdData[11:0];
          end
        end
        sswb_pkg::SSWB_CMD_WR_SET: begin
          s_nxt.mode = link.cmdData[1:0];
          s_nxt.ptr = link.cmdData[7:4] > `SSWB_PAT_LAST ? `SSWB_PAT_LAST
                      : link.cmdData[7:4];
          s_nxt.addr = link.cmdData[11:8];
          s_nxt.size = link.cmdData[15:12];
        end
        default: begin
        end
      endcase
    end
    // balance outputs; sleep stops manual balancing
    s_nxt.fet = 12'h000;
    if (s_r.balance_enable_bit) begin
      case (s_r.mode)
        sswb_pkg::SSWB_BM_MANUAL: begin
          if (s_r.st == sswb_pkg::SSWB_ST_AWAKE) begin
            s_nxt.fet = curPat;
          end
        end
        sswb_pkg::SSWB_BM_TIMED: begin
          if (balDurDone) begin
            s_nxt.balance_enable_bit = 1'b0;
            s_nxt.eob = 1'b1;
          end else begin
            s_nxt.fet = curPat;
          end
        end
        sswb_pkg::SSWB_BM_AUTO: begin
          s_nxt.fet = curPat;
          if (autoCycleTick) begin
            if (s_r.ptr >= `SSWB_PAT_LAST || s_r.ptr == 4'h0
                || s_r.pat[(s_r.ptr+4'h1)*12 +: 12] == 12'h000) begin
              s_nxt.ptr = `SSWB_PAT_FIRST;
            end else begin
              s_nxt.ptr = s_r.ptr + 4'h1;
            end
          end
        end
        default: s_nxt.fet = 12'h000;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_r <= '0;
      s_r.st <= sswb_pkg::SSWB_ST_AWAKE;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign link.rspValid = s_r.rspV;
  assign link.rspCode = s_r.rsp;
  assign devAddr = s_r.addr;
  assign asleep = s_r.st == sswb_pkg::SSWB_ST_ASLEEP;
  assign wakeOut = s_r.wakeLvl;
  assign balanceEnableBit = s_r.balance_enable_bit;
  assign balMode = s_r.mode;
  assign patPtr = s_r.ptr;
  assign endOfBalance = s_r.eob;
  assign balFet = s_r.fet;
endmodule : sswb_device

// ### src/sswb_defines.svh
// constants shared by both ends of the sleep/wake/balance command link
// Contract
// - sleep accepted only at broadcast address, else NAK
// - topmost device acknowledges a valid sleep
// - sleep waits; valid traffic cancels pending sleep
// - repeated sleep restarts the wait timer
// - sleep entry within 500 us at 100 MHz
// - no fault timeout on sleep requests; host times out sleep requests as it does wakeups
// - unrequested device sleeps on enabled watchdog expiry
// - in sleep only link, oscillator, registers stay; here timed and auto balancing keep driving the FETs in sleep
// - wakeup only at broadcast, else master NAKs; here an asleep master drops an individual wakeup without a NAK
// - master wakes, sends 4 kHz wake burst upward
// - ignore first port while sending wake burst
// - topmost waits before wakeup ACK
// - host expects wakeup ACK within 63/100 ms
// - reset clears registers, stack address, size; silent
// - broadcast reset has no effect
// - host resets top down, then re-identifies
// - balance enable sets enable bit, may broadcast
// - balance inhibit clears enable bit, may broadcast
// - twelve independent balance FET outputs
// - timed mode switches outputs off at duration end
// - thirteen pattern locations; manual/timed use pointer zero; here they read the location at the pointer set by SSWB_CMD_WR_SET
// - auto steps locations 1..12, zero wraps to 1
// - mode 00 off, 01 manual, 10 timed, 11 auto
`ifndef SSWB_DEFINES_SVH
`define SSWB_DEFINES_SVH
`define SSWB_ADDR_ALL       4'hF
`define SSWB_CLK_MHZ        100
`define SSWB_SLEEP_WAIT_US  500
`define SSWB_SLEEP_WAIT_CYC (`SSWB_SLEEP_WAIT_US * `SSWB_CLK_MHZ)
`define SSWB_WAKE_HZ        4000
`define SSWB_WAKE_HALF_CYC  ((`SSWB_CLK_MHZ * 1000000) / (2 * `SSWB_WAKE_HZ))
`define SSWB_WAKE_PULSES    4
`define SSWB_TOP_WAIT_US    2000
`define SSWB_TOP_WAIT_CYC   (`SSWB_TOP_WAIT_US * `SSWB_CLK_MHZ)
`define SSWB_WAKE_ACK_MS8   63
`define SSWB_WAKE_ACK_MS14  100
`define SSWB_HOST_TMO_CYC   (`SSWB_WAKE_ACK_MS14 * 1000 * `SSWB_CLK_MHZ)
`define SSWB_PAT_LOCS       13
`define SSWB_PAT_LAST       4'hC
`define SSWB_PAT_FIRST      4'h1
`define SSWB_REG_CTRL       8'h00
`define SSWB_REG_STAT       8'h04
`define SSWB_REG_RESP       8'h08
`endif

// ### src/sswb_pkg.sv
// shared types of the sleep/wake/balance command link
package sswb_pkg;
  typedef enum logic [3:0] {
    SSWB_CMD_NONE    = 4'h0,
    SSWB_CMD_SLEEP   = 4'h1,
    SSWB_CMD_WAKE    = 4'h2,
    SSWB_CMD_RESET   = 4'h3,
    SSWB_CMD_BAL_EN  = 4'h4,
    SSWB_CMD_BAL_INH = 4'h5,
    SSWB_CMD_WR_PAT  = 4'h6,
    SSWB_CMD_WR_SET  = 4'h7,
    SSWB_CMD_PING    = 4'h8
  } sswb_cmd_t;
  typedef enum logic [1:0] {
    SSWB_RSP_NONE = 2'h0,
    SSWB_RSP_ACK  = 2'h1,
    SSWB_RSP_NAK  = 2'h2
  } sswb_rsp_t;
  typedef enum logic [1:0] {
    SSWB_BM_OFF    = 2'b00,
    SSWB_BM_MANUAL = 2'b01,
    SSWB_BM_TIMED  = 2'b10,
    SSWB_BM_AUTO   = 2'b11
  } sswb_bmode_t;
  typedef enum logic [3:0] {
    SSWB_ST_AWAKE   = 4'b0001,
    SSWB_ST_PEND    = 4'b0010,
    SSWB_ST_ASLEEP  = 4'b0100,
    SSWB_ST_WAKEOUT = 4'b1000
  } sswb_state_t;
endpackage : sswb_pkg

// ### src/sswb_link_if.sv
// command link between host controller and stack device
`timescale 1ns/1ns
interface sswb_link_if;
  logic                cmdValid;
  sswb_pkg::sswb_cmd_t cmdCode;
  logic [3:0]          cmdAddr;
  logic [15:0]         cmdData;
  logic                rspValid;
  sswb_pkg::sswb_rsp_t rspCode;
  logic                wakeIn;
  modport device (input cmdValid, input cmdCode, input cmdAddr, input cmdData,
                  output rspValid, output rspCode, input wakeIn);
  modport host   (output cmdValid, output cmdCode, output cmdAddr, output cmdData,
                  input rspValid, input rspCode, output wakeIn);
endinterface : sswb_link_if

// ### src/sswb_host.sv
// host end: APB-programmed command issuer with response watchdog
`timescale 1ns/1ns
`include "sswb_defines.svh"
module sswb_host (
  input  wire logic   clk,
  input  wire logic   sys_rst,
  sswb_link_if.host   link,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr
);
  typedef struct packed {
    logic        busy;
    logic [31:0] tmo;
    logic        cmdV;
    sswb_pkg::sswb_cmd_t code;
    logic [3:0]  addr;
    logic [15:0] data;
    logic        gotAck;
    logic        gotNak;
    logic        fault;
    logic [31:0] rd;
  } sswb_host_t;
  sswb_host_t s_r, s_nxt;
  logic wr, rd;
  always_comb begin
    s_nxt = s_r;
    s_nxt.cmdV = 1'b0;
    wr = psel && penable && pwrite;
    rd = psel && !penable && !pwrite;
    if (rd) begin
      case (paddr)
        `SSWB_REG_STAT: s_nxt.rd = {28'h0, s_r.fault, s_r.gotNak, s_r.gotAck, s_r.busy};
        `SSWB_REG_CTRL: s_nxt.rd = {8'h0, s_r.data, s_r.addr, s_r.code};
        default:        s_nxt.rd = 32'h0;
      endcase
    end
    if (s_r.busy) begin
      s_nxt.tmo = s_r.tmo + 32'h1;
      if (s_r.tmo >= `SSWB_HOST_TMO_CYC - 1) begin
        s_nxt.busy = 1'b0;
        s_nxt.fault = 1'b1;
      end
    end
    if (link.rspValid) begin
      s_nxt.busy = 1'b0;
      s_nxt.gotAck = s_r.gotAck || link.rspCode == sswb_pkg::SSWB_RSP_ACK;
      s_nxt.gotNak = s_r.gotNak || link.rspCode == sswb_pkg::SSWB_RSP_NAK;
    end
    if (wr && paddr == `SSWB_REG_CTRL) begin
      // software sequences resets top-down itself
      s_nxt.code = sswb_pkg::sswb_cmd_t'(pwdata[3:0]);
      s_nxt.addr = pwdata[7:4];
      s_nxt.data = pwdata[23:8];
      s_nxt.cmdV = 1'b1;
      s_nxt.busy = pwdata[3:0] == sswb_pkg::SSWB_CMD_WAKE
                   || pwdata[3:0] == sswb_pkg::SSWB_CMD_SLEEP;
      s_nxt.tmo = 32'h0;
      s_nxt.gotAck = 1'b0;
      s_nxt.gotNak = 1'b0;
      s_nxt.fault = 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign link.cmdValid = s_r.cmdV;
  assign link.cmdCode = s_r.code;
  assign link.cmdAddr = s_r.addr;
  assign link.cmdData = s_r.data;
  assign link.wakeIn = 1'b0;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = s_r.rd;
endmodule : sswb_host

// ### tb/sswb_link_checker.sv
// assertions on the command link joining host and stack device
`timescale 1ns/1ns
`include "sswb_defines.svh"
module sswb_link_checker (
  input wire logic           clk,
  input wire logic           sys_rst,
  input wire logic           cmdValid,
  input sswb_pkg::sswb_cmd_t cmdCode,
  input wire logic [3:0]     cmdAddr,
  input wire logic [15:0]    cmdData,
  input wire logic           rspValid,
  input sswb_pkg::sswb_rsp_t rspCode,
  input wire logic           wakeIn
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire bcast = cmdAddr == `SSWB_ADDR_ALL;
  wire nak   = rspValid && rspCode == sswb_pkg::SSWB_RSP_NAK;
  wire ack   = rspValid && rspCode == sswb_pkg::SSWB_RSP_ACK;
  wire sleep = cmdValid && cmdCode == sswb_pkg::SSWB_CMD_SLEEP;
  wire wake  = cmdValid && cmdCode == sswb_pkg::SSWB_CMD_WAKE;
  wire rst   = cmdValid && cmdCode == sswb_pkg::SSWB_CMD_RESET;
  wire bal   = cmdValid && (cmdCode == sswb_pkg::SSWB_CMD_BAL_EN
               || cmdCode == sswb_pkg::SSWB_CMD_BAL_INH);
  sleep_nak_a: assert property (sleep && !bcast |=> nak)
    else $error("individual sleep not refused");
  sleep_ack_a: assert property (sleep && bcast |=> ack)
    else $error("broadcast sleep not acknowledged");
  wake_nak_a: assert property (wake && !bcast |=> nak)
    else $error("individual wakeup not refused");
  reset_silent_a: assert property (rst |=> !rspValid [*3])
    else $error("reset request answered");
  bal_bcast_a: assert property (bal && bcast |=> !nak)
    else $error("broadcast balance request refused");
  wake_quiet_a: assert property (wake && bcast |=> !ack [*8])
    else $error("wakeup acknowledged without waiting");
  nak_cause_a: assert property (nak |-> $past(cmdValid))
    else $error("refusal without a request");
  rsp_code_a: assert property (rspValid |-> ack || nak)
    else $error("response with no code");
  cover property (sleep && bcast ##1 ack);
  cover property (nak);
  cover property (wake && bcast);
endmodule : sswb_link_checker

// ### tb/testbench.sv
// self-checking bench: host and stack device joined over the command link
`timescale 1ns/1ns
`include "sswb_defines.svh"
`define CHK(n, e, g) begin checkCount++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
`define WAITC(c, m) begin for (w = 0; w < (m) && !(c); w++) @(posedge clk); \
  `CHK("wait", 1'b1, c) if (!(c)) stop_test(); end
module testbench;
  logic        clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic        wdogEn = 0, wdogExpired = 0, balDurDone = 0, autoCycleTick = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic        pready, pslverr, asleep, wakeOut, balanceEnableBit, endOfBalance;
  logic [3:0]  devAddr, patPtr, tgt;
  logic [1:0]  balMode;
  logic [11:0] balFet;
  logic [23:0] lastCmd;
  int          cmdSeen = 0, miscompares = 0, checkCount = 0, w, n0;
  sswb_pkg::sswb_rsp_t rsp;
  always #5 clk = ~clk;
  sswb_link_if lnk ();
  sswb_host i_sswb_host (.clk(clk), .sys_rst(sys_rst), .link(lnk), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  sswb_device i_sswb_device (.clk(clk), .sys_rst(sys_rst), .link(lnk), .isTop(1'b1),
    .isMaster(1'b1), .wdogEn(wdogEn), .wdogExpired(wdogExpired), .balDurDone(balDurDone),
    .autoCycleTick(autoCycleTick), .devAddr(devAddr), .asleep(asleep), .wakeOut(wakeOut),
    .balanceEnableBit(balanceEnableBit), .balMode(balMode), .patPtr(patPtr),
    .endOfBalance(endOfBalance), .balFet(balFet));
  sswb_link_checker i_sswb_link_checker (.clk(clk), .sys_rst(sys_rst),
    .cmdValid(lnk.cmdValid), .cmdCode(lnk.cmdCode), .cmdAddr(lnk.cmdAddr),
    .cmdData(lnk.cmdData), .rspValid(lnk.rspValid), .rspCode(lnk.rspCode),
    .wakeIn(lnk.wakeIn));
  always @(posedge clk) begin
    if (lnk.cmdValid) rsp <= sswb_pkg::SSWB_RSP_NONE;
    else if (lnk.rspValid) rsp <= lnk.rspCode;
    if (lnk.cmdValid) begin
      lastCmd <= {lnk.cmdData, lnk.cmdAddr, lnk.cmdCode};
      cmdSeen <= cmdSeen + 1;
    end
  end
  task stop_test;
    if (miscompares == 0 && checkCount > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    w = 0;
    do @(posedge clk); while (pready !== 1'b1 && ++w < 20);
    `CHK("pready", 1'b1, pready)
    `CHK("pslverr", 1'b0, pslverr)
    rdat = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task cmd(input logic [3:0] c, input logic [3:0] a, input logic [15:0] d);
    apb(1'b1, `SSWB_REG_CTRL, {8'h00, d, a, c});
    repeat (4) @(posedge clk);
    `CHK("link cmd", {d, a, c}, lastCmd)
  endtask : cmd
  task setm(input logic [1:0] m, input logic [3:0] p, input logic [3:0] na);
    cmd(sswb_pkg::SSWB_CMD_WR_SET, tgt, {4'h0, na, p, 2'b00, m});
    tgt = na;
    `CHK("mode", m, balMode)
    `CHK("pointer", p, patPtr)
    `CHK("address", na, devAddr)
  endtask : setm
  task tick(input logic [3:0] e);
    autoCycleTick <= 1'b1;
    @(posedge clk);
    autoCycleTick <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("auto pointer", e, patPtr)
  endtask : tick
  initial begin
    tgt = 4'h0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    n0 = cmdSeen;
    // a write off the map must not reach the link
    apb(1'b1, 8'h40, 32'h0000_00F1);
    repeat (4) @(posedge clk);
    `CHK("unmapped", n0, cmdSeen)
    for (int m = 0; m < 4; m++) setm(m[1:0], 4'h0, 4'h0);
    cmd(sswb_pkg::SSWB_CMD_WR_PAT, tgt, 16'h0A5C);
    setm(2'b01, 4'h0, 4'h0);
    cmd(sswb_pkg::SSWB_CMD_BAL_EN, `SSWB_ADDR_ALL, 16'h0000);
    `CHK("enable", 1'b1, balanceEnableBit)
    `CHK("fets", 12'hA5C, balFet)
    cmd(sswb_pkg::SSWB_CMD_BAL_INH, `SSWB_ADDR_ALL, 16'h0000);
    `CHK("enable", 1'b0, balanceEnableBit)
    `CHK("fets", 12'h000, balFet)
    setm(2'b10, 4'h0, 4'h0);
    cmd(sswb_pkg::SSWB_CMD_BAL_EN, tgt, 16'h0000);
    `CHK("fets", 12'hA5C, balFet)
    balDurDone <= 1'b1;
    @(posedge clk);
    balDurDone <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("fets", 12'h000, balFet)
    `CHK("enable", 1'b0, balanceEnableBit)
    `CHK("end flag", 1'b1, endOfBalance)
    cmd(sswb_pkg::SSWB_CMD_WR_PAT, tgt, 16'h1001);
    cmd(sswb_pkg::SSWB_CMD_WR_PAT, tgt, 16'h2802);
    cmd(sswb_pkg::SSWB_CMD_WR_PAT, tgt, 16'h3000);
    setm(2'b11, 4'h0, 4'h0);
    cmd(sswb_pkg::SSWB_CMD_BAL_EN, tgt, 16'h0000);
    tick(4'h1);
    tick(4'h2);
    `CHK("auto fets", 12'h802, balFet)
    tick(4'h1);
    cmd(sswb_pkg::SSWB_CMD_BAL_INH, tgt, 16'h0000);
    setm(2'b01, 4'h0, 4'h5);
    cmd(sswb_pkg::SSWB_CMD_RESET, `SSWB_ADDR_ALL, 16'h0000);
    `CHK("address", 4'h5, devAddr)
    `CHK("mode", 2'b01, balMode)
    cmd(sswb_pkg::SSWB_CMD_RESET, tgt, 16'h0000);
    `CHK("address", 4'h0, devAddr)
    `CHK("mode", 2'b00, balMode)
    `CHK("silent", sswb_pkg::SSWB_RSP_NONE, rsp)
    cmd(sswb_pkg::SSWB_CMD_SLEEP, 4'h0, 16'h0000);
    `CHK("sleep rsp", sswb_pkg::SSWB_RSP_NAK, rsp)
    apb(1'b0, `SSWB_REG_STAT, 32'h0);
    `CHK("status", 2'b10, rdat[2:1])
    cmd(sswb_pkg::SSWB_CMD_WAKE, 4'h0, 16'h0000);
    `CHK("wake rsp", sswb_pkg::SSWB_RSP_NAK, rsp)
    cmd(sswb_pkg::SSWB_CMD_SLEEP, `SSWB_ADDR_ALL, 16'h0000);
    `CHK("sleep rsp", sswb_pkg::SSWB_RSP_ACK, rsp)
    repeat (1000) @(posedge clk);
    cmd(sswb_pkg::SSWB_CMD_SLEEP, `SSWB_ADDR_ALL, 16'h0000);
    `CHK("sleep rsp", sswb_pkg::SSWB_RSP_ACK, rsp)
    // past the first request's wait, still short of the restarted one
    repeat (49500) @(posedge clk);
    `CHK("asleep", 1'b0, asleep)
    `WAITC(asleep, 500)
    cmd(sswb_pkg::SSWB_CMD_WAKE, `SSWB_ADDR_ALL, 16'h0000);
    `CHK("asleep", 1'b0, asleep)
    `WAITC(wakeOut, 30000)
    // the wake burst is long, so this request lands inside it
    cmd(sswb_pkg::SSWB_CMD_BAL_EN, `SSWB_ADDR_ALL, 16'h0000);
    `CHK("enable", 1'b0, balanceEnableBit)
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    wdogExpired <= 1'b1;
    repeat (5) @(posedge clk);
    `CHK("asleep", 1'b0, asleep)
    wdogEn <= 1'b1;
    `WAITC(asleep, 20)
    stop_test();
  end
endmodule : testbench
